// File: lomb_mask_bank.sv
// interrupt mask bank of loop channel one with sticky event status
// assumes apb3 master on pclk; event pulses synchronous to pclk

`timescale 1ns/1ps
`default_nettype none

module lomb_mask_bank
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [lomb_pkg::LOMB_ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output var logic [31:0] prdata,
	output var logic pready,
	output var logic pslverr,
	// loop events
	input wire lomb_pkg::lomb_ev_s ev,
	// interrupt request
	output var logic irq
);
	import lomb_pkg::*;

	// ---------------------------------------------------------
	// decode
	// ---------------------------------------------------------
	lomb_state_s s_q;
	lomb_state_s s_d;
	logic [4:0][7:0] ev_a;
	logic [9:0] idx;
	logic word_ok;
	logic mask_hit;
	logic stat_hit;
	logic [9:0] mask_off;
	logic [9:0] stat_off;
	logic [2:0] bank;
	logic setup;
	logic access;
	logic mask_wr;
	logic stat_wr;

	assign ev_a = ev;
	assign idx = paddr[LOMB_ADDR_W-1:2];
	assign word_ok = (paddr[1:0] == 2'h0);
	assign mask_off = idx - LOMB_LOCK_IDX;
	assign stat_off = idx - LOMB_STAT_IDX;
	assign mask_hit = word_ok && (idx >= LOMB_LOCK_IDX) && (idx <= LOMB_ANALOG_IDX);
	assign stat_hit = word_ok && (idx >= LOMB_STAT_IDX) && (stat_off < 10'(LOMB_BANKS));
	assign bank = mask_hit ? mask_off[2:0] : stat_off[2:0];
	assign setup = psel && !penable;
	// access edge is the one where pready is sampled high
	assign access = psel && penable && s_q.rdy;
	assign mask_wr = access && pwrite && mask_hit;
	assign stat_wr = access && pwrite && stat_hit;

	// ---------------------------------------------------------
	// next state
	// ---------------------------------------------------------
	always_comb
	begin
		s_d = s_q;
		// zero wait states: answer in the first access cycle
		s_d.rdy = setup;
		s_d.err = setup && !(mask_hit || stat_hit);
		s_d.rdata = 32'h0000_0000;
		// read data is a snapshot taken in the setup cycle
		if (setup && !pwrite && mask_hit)
		begin
			s_d.rdata[7:0] = s_q.mask[bank];
		end
		if (setup && !pwrite && stat_hit)
		begin
			s_d.rdata[7:0] = s_q.stat[bank];
		end
		for (int b = 0; b < LOMB_BANKS; b++)
		begin
			// [R1]..[R16] mask writes, reserved bits stay zero except acquisition bits 1:0
			if (mask_wr && (bank == 3'(b)))
			begin
				s_d.mask[b] = pwdata[7:0] & LOMB_WR_BITS[b];
			end
			// [R17] detection ignores mask; set wins over clear
			if (stat_wr && (bank == 3'(b)))
			begin
				s_d.stat[b] = s_q.stat[b] & ~pwdata[7:0];
			end
			s_d.stat[b] = s_d.stat[b] | (ev_a[b] & LOMB_EV_BITS[b]);
		end
		// [R18] request while any unmasked status bit is set
		s_d.irq = |(s_d.stat & s_d.mask);
	end

	// ---------------------------------------------------------
	// state register
	// ---------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			// [R18] masks cleared by reset
			s_q.mask <= {LOMB_BANKS{LOMB_MASK_RST}};
			s_q.stat <= {LOMB_BANKS{LOMB_STAT_RST}};
			s_q.rdy <= 1'b0;
			s_q.err <= 1'b0;
			s_q.rdata <= 32'h0000_0000;
			s_q.irq <= 1'b0;
		end
		else
		begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.err;
	assign irq = s_q.irq;

	// ---------------------------------------------------------
	// checks
	// ---------------------------------------------------------
	// an event is counted only when its mask is not being rewritten
	logic quiet;
	assign quiet = !mask_wr;

	AST_FCLAMP_OFF: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_FCLAMP_OFF] && s_q.mask[LOMB_B_LOCK][LOMB_FCLAMP_OFF]) |=> irq
	) else $error("clamp off event did not raise the request");

	AST_SLEW_ON: assert property ( // [R2]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_SLEW_ON] && s_q.mask[LOMB_B_LOCK][LOMB_SLEW_ON]) |=> irq
	) else $error("slew limiter event did not raise the request");

	AST_FREQ_UNLK: assert property ( // [R3]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_FREQ_UNLK] && s_q.mask[LOMB_B_LOCK][LOMB_FREQ_UNLK])
		|=> (irq && s_q.stat[LOMB_B_LOCK][LOMB_FREQ_UNLK])
	) else $error("frequency unlock did not raise the request");

	AST_FREQ_LK: assert property ( // [R4]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_FREQ_LK] && s_q.mask[LOMB_B_LOCK][LOMB_FREQ_LK]) |=> irq
	) else $error("frequency lock did not raise the request");

	AST_PHASE_LK: assert property ( // [R5]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_PHASE_LK] && s_q.mask[LOMB_B_LOCK][LOMB_PHASE_LK]) |=> irq
	) else $error("phase lock did not raise the request");

	AST_REF_SW: assert property ( // [R6]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_REF_SW] && s_q.mask[LOMB_B_STATE][LOMB_REF_SW]) |=> irq
	) else $error("reference switch did not raise the request");

	AST_HOLDOVER: assert property ( // [R7]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_HOLDOVER] && s_q.mask[LOMB_B_STATE][LOMB_HOLDOVER]) |=> irq
	) else $error("holdover entry did not raise the request");

	AST_HITLESS_OUT: assert property ( // [R8]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_HITLESS_OUT] && s_q.mask[LOMB_B_STATE][LOMB_HITLESS_OUT]) |=> irq
	) else $error("hitless exit did not raise the request");

	AST_HISTORY: assert property ( // [R9]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_HISTORY] && s_q.mask[LOMB_B_STATE][LOMB_HISTORY]) |=> irq
	) else $error("history update did not raise the request");

	AST_STATE_RSVD: assert property ( // [R10]
		@(posedge pclk) disable iff (!presetn)
		!s_q.mask[LOMB_B_STATE][LOMB_STATE_RSVD] && !s_q.stat[LOMB_B_STATE][LOMB_STATE_RSVD]
	) else $error("reserved state bit became set");

	AST_DIV_RESYNC: assert property ( // [R11]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.acq[LOMB_DIV_RESYNC] && s_q.mask[LOMB_B_ACQ][LOMB_DIV_RESYNC]) |=> irq
	) else $error("divider resync did not raise the request");

	AST_FACQ_DONE: assert property ( // [R12]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.acq[LOMB_FACQ_DONE] && s_q.mask[LOMB_B_ACQ][LOMB_FACQ_DONE]) |=> irq
	) else $error("fast acquisition done did not raise the request");

	AST_PROF_RSVD: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(s_q.mask[LOMB_B_PROF][7:6] == 2'h0) && (s_q.mask[LOMB_B_ANALOG][7:5] == 3'h0)
	) else $error("reserved profile or analog mask bit set");

	AST_DIST_SYNC: assert property ( // [R14]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.analog[LOMB_DIST_SYNC] && s_q.mask[LOMB_B_ANALOG][LOMB_DIST_SYNC]) |=> irq
	) else $error("distribution sync did not raise the request");

	AST_ALOOP_UNLK: assert property ( // [R15]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.analog[LOMB_ALOOP_UNLK] && s_q.mask[LOMB_B_ANALOG][LOMB_ALOOP_UNLK]) |=> irq
	) else $error("analog unlock did not raise the request");

	AST_CAL_START: assert property ( // [R16]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.analog[LOMB_CAL_START] && s_q.mask[LOMB_B_ANALOG][LOMB_CAL_START]) |=> irq
	) else $error("calibration start did not raise the request");

	AST_MASKED_SEEN: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		(ev.lock[LOMB_PHASE_UNLK] && !s_q.mask[LOMB_B_LOCK][LOMB_PHASE_UNLK])
		|=> s_q.stat[LOMB_B_LOCK][LOMB_PHASE_UNLK]
		##1 (s_q.stat[LOMB_B_LOCK][LOMB_PHASE_UNLK] || $past(stat_wr))
	) else $error("masked event was not recorded");

	AST_IRQ_LEVEL: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		irq == (|(s_q.stat & s_q.mask))
	) else $error("request does not match unmasked status");

	AST_WRITE_TAKES: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		(mask_wr && (bank == 3'h0)) |=> (s_q.mask[LOMB_B_LOCK] == $past(pwdata[7:0]))
	) else $error("lock mask write not stored");

	AST_ANSWER: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		setup |=> (pready && (pslverr == !$past(mask_hit || stat_hit)))
	) else $error("apb answer missing or wrong");

	AST_FCLAMP_ON: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_FCLAMP_ON] && s_q.mask[LOMB_B_LOCK][LOMB_FCLAMP_ON]) |=> irq
	) else $error("clamp on event did not raise the request");

	AST_SLEW_OFF: assert property ( // [R2]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_SLEW_OFF] && s_q.mask[LOMB_B_LOCK][LOMB_SLEW_OFF]) |=> irq
	) else $error("slew limiter off did not raise the request");

	AST_PHASE_UNLK: assert property ( // [R5]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.lock[LOMB_PHASE_UNLK] && s_q.mask[LOMB_B_LOCK][LOMB_PHASE_UNLK]) |=> irq
	) else $error("phase unlock did not raise the request");

	AST_FREERUN: assert property ( // [R7]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_FREERUN] && s_q.mask[LOMB_B_STATE][LOMB_FREERUN]) |=> irq
	) else $error("freerun entry did not raise the request");

	AST_HITLESS_IN: assert property ( // [R8]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_HITLESS_IN] && s_q.mask[LOMB_B_STATE][LOMB_HITLESS_IN]) |=> irq
	) else $error("hitless entry did not raise the request");

	AST_PSTEP: assert property ( // [R10]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.state[LOMB_PSTEP] && s_q.mask[LOMB_B_STATE][LOMB_PSTEP]) |=> irq
	) else $error("phase step did not raise the request");

	AST_FACQ_START: assert property ( // [R12]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.acq[LOMB_FACQ_START] && s_q.mask[LOMB_B_ACQ][LOMB_FACQ_START]) |=> irq
	) else $error("fast acquisition start did not raise the request");

	AST_PROF0: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[0] && s_q.mask[LOMB_B_PROF][0]) |=> irq
	) else $error("profile 0 activation did not raise the request");

	AST_PROF1: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[1] && s_q.mask[LOMB_B_PROF][1]) |=> irq
	) else $error("profile 1 activation did not raise the request");

	AST_PROF2: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[2] && s_q.mask[LOMB_B_PROF][2]) |=> irq
	) else $error("profile 2 activation did not raise the request");

	AST_PROF3: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[3] && s_q.mask[LOMB_B_PROF][3]) |=> irq
	) else $error("profile 3 activation did not raise the request");

	AST_PROF4: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[4] && s_q.mask[LOMB_B_PROF][4]) |=> irq
	) else $error("profile 4 activation did not raise the request");

	AST_PROF5: assert property ( // [R13]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.profile[5] && s_q.mask[LOMB_B_PROF][5]) |=> irq
	) else $error("profile 5 activation did not raise the request");

	AST_ALOOP_LK: assert property ( // [R15]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.analog[LOMB_ALOOP_LK] && s_q.mask[LOMB_B_ANALOG][LOMB_ALOOP_LK]) |=> irq
	) else $error("analog lock did not raise the request");

	AST_CAL_DONE: assert property ( // [R16]
		@(posedge pclk) disable iff (!presetn)
		(quiet && ev.analog[LOMB_CAL_DONE] && s_q.mask[LOMB_B_ANALOG][LOMB_CAL_DONE]) |=> irq
	) else $error("calibration done did not raise the request");

	AST_ACQ_RSVD: assert property ( // [R11]
		@(posedge pclk) disable iff (!presetn)
		(s_q.mask[LOMB_B_ACQ][7:5] == 3'h0) && (s_q.stat[LOMB_B_ACQ][7:5] == 3'h0)
		&& (s_q.stat[LOMB_B_ACQ][1:0] == 2'h0)
	) else $error("reserved acquisition bit set");

	AST_STAT_RSVD: assert property ( // [R14]
		@(posedge pclk) disable iff (!presetn)
		(s_q.stat[LOMB_B_PROF][7:6] == 2'h0) && (s_q.stat[LOMB_B_ANALOG][7:5] == 3'h0)
	) else $error("reserved profile or analog status bit set");

	AST_MASK_BLOCKS: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		(!mask_wr && ((s_q.stat & s_q.mask) == 40'h00_0000_0000) && ((ev_a & s_q.mask) == 40'h00_0000_0000))
		|=> !irq
	) else $error("masked event raised the request");

	AST_SET_WINS: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		(stat_wr && (bank == 3'h0) && pwdata[LOMB_FREQ_LK] && ev.lock[LOMB_FREQ_LK])
		|=> s_q.stat[LOMB_B_LOCK][LOMB_FREQ_LK]
	) else $error("clear beat a new event");

	AST_CLEAR: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		(stat_wr && (bank == 3'h0) && pwdata[LOMB_FREQ_LK] && !ev.lock[LOMB_FREQ_LK])
		|=> !s_q.stat[LOMB_B_LOCK][LOMB_FREQ_LK]
	) else $error("write one did not clear status");

	AST_RDY_ONE: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		pready |=> !pready
	) else $error("ready held longer than one cycle");

	AST_ERR_WITH_RDY: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready
	) else $error("error without ready");

	AST_MISALIGN: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		(setup && (paddr[1:0] != 2'h0)) |=> pslverr
	) else $error("misaligned access not refused");

	AST_RDATA_IDLE: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		!pready |-> (prdata == 32'h0000_0000)
	) else $error("read data outside an answer");

	AST_MASK_HOLD: assert property ( // [R18]
		@(posedge pclk) disable iff (!presetn)
		!mask_wr |=> $stable(s_q.mask)
	) else $error("mask changed without a write");

	AST_STAT_HOLD: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		(!stat_wr && (ev_a == 40'h00_0000_0000)) |=> $stable(s_q.stat)
	) else $error("status changed without event or clear");

	AST_READ_LOCK: assert property ( // [R1]
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && mask_hit && (bank == 3'h0))
		|=> (prdata == {24'h000000, $past(s_q.mask[LOMB_B_LOCK])})
	) else $error("lock mask read data wrong");

	AST_READ_STAT: assert property ( // [R17]
		@(posedge pclk) disable iff (!presetn)
		(setup && !pwrite && stat_hit && (bank == 3'h0))
		|=> (prdata == {24'h000000, $past(s_q.stat[LOMB_B_LOCK])})
	) else $error("lock status read data wrong");

endmodule : lomb_mask_bank

`default_nettype wire

// File: lomb_pkg.sv
// constants and carrier types of the loop one interrupt mask bank
// assumes one 100 MHz apb clock shared with the loop event sources
//
// Summary of operation
// [R1] lock bits 7/6: frequency clamp off/on
// [R2] lock bits 5/4: phase slew limiter off/on
// [R3] lock bit 3: frequency lock lost
// [R4] lock bit 2: frequency lock gained
// [R5] lock bits 1/0: phase lock lost/gained
// [R6] state bit 7: reference input switched
// [R7] state bits 6/5: freerun/holdover entered
// [R8] state bits 4/3: hitless entered/exited
// [R9] state bit 2: holdover history updated
// [R10] state bit 0 phase step; bit 1 reads zero
// [R11] acquisition bit 4 divider resync; 7:5 zero
// [R12] acquisition bits 3/2 complete/start; 1:0 reserved
// [R13] profile bits 5:0 per profile; 7:6 zero
// [R14] analog bit 4 distribution synced; 7:5 zero
// [R15] analog bits 3/2: analog lock lost/gained
// [R16] analog bits 1/0: calibration done/started
// [R17] zero mask blocks request, detection continues
// [R18] request on any unmasked event; masks reset zero

`default_nettype none

package lomb_pkg;

	// -------------------------------------------------------
	// register indices; byte address is four times the index
	// -------------------------------------------------------
	localparam logic [9:0] LOMB_LOCK_IDX = 10'h116;
	localparam logic [9:0] LOMB_STATE_IDX = 10'h117;
	localparam logic [9:0] LOMB_ACQ_IDX = 10'h118;
	localparam logic [9:0] LOMB_PROF_IDX = 10'h119;
	localparam logic [9:0] LOMB_ANALOG_IDX = 10'h11A;
	// sticky status banks, same order and layout as the masks
	localparam logic [9:0] LOMB_STAT_IDX = 10'h120;
	localparam int LOMB_BANKS = 5;
	localparam int LOMB_ADDR_W = 12;

	// -------------------------------------------------------
	// bank numbers
	// -------------------------------------------------------
	localparam int LOMB_B_LOCK = 0;
	localparam int LOMB_B_STATE = 1;
	localparam int LOMB_B_ACQ = 2;
	localparam int LOMB_B_PROF = 3;
	localparam int LOMB_B_ANALOG = 4;

	// -------------------------------------------------------
	// field positions
	// -------------------------------------------------------
	localparam int LOMB_FCLAMP_OFF = 7;
	localparam int LOMB_FCLAMP_ON = 6;
	localparam int LOMB_SLEW_OFF = 5;
	localparam int LOMB_SLEW_ON = 4;
	localparam int LOMB_FREQ_UNLK = 3;
	localparam int LOMB_FREQ_LK = 2;
	localparam int LOMB_PHASE_UNLK = 1;
	localparam int LOMB_PHASE_LK = 0;
	localparam int LOMB_REF_SW = 7;
	localparam int LOMB_FREERUN = 6;
	localparam int LOMB_HOLDOVER = 5;
	localparam int LOMB_HITLESS_IN = 4;
	localparam int LOMB_HITLESS_OUT = 3;
	localparam int LOMB_HISTORY = 2;
	localparam int LOMB_STATE_RSVD = 1;
	localparam int LOMB_PSTEP = 0;
	localparam int LOMB_DIV_RESYNC = 4;
	localparam int LOMB_FACQ_DONE = 3;
	localparam int LOMB_FACQ_START = 2;
	localparam int LOMB_DIST_SYNC = 4;
	localparam int LOMB_ALOOP_UNLK = 3;
	localparam int LOMB_ALOOP_LK = 2;
	localparam int LOMB_CAL_DONE = 1;
	localparam int LOMB_CAL_START = 0;

	// -------------------------------------------------------
	// writable bits, event bits and reset values per bank
	// -------------------------------------------------------
	localparam logic [4:0][7:0] LOMB_WR_BITS = {8'h1F, 8'h3F, 8'h1F, 8'hFD, 8'hFF};
	localparam logic [4:0][7:0] LOMB_EV_BITS = {8'h1F, 8'h3F, 8'h1C, 8'hFD, 8'hFF};
	localparam logic [7:0] LOMB_MASK_RST = 8'h00;
	localparam logic [7:0] LOMB_STAT_RST = 8'h00;

	// -------------------------------------------------------
	// carriers
	// -------------------------------------------------------
	// one-cycle event pulses; lock bank in the low byte
	typedef struct packed {
		logic [7:0] analog;
		logic [7:0] profile;
		logic [7:0] acq;
		logic [7:0] state;
		logic [7:0] lock;
	} lomb_ev_s;

	typedef struct packed {
		logic [4:0][7:0] mask;
		logic [4:0][7:0] stat;
		logic rdy;
		logic err;
		logic [31:0] rdata;
		logic irq;
	} lomb_state_s;

endpackage : lomb_pkg

`default_nettype wire

// File: lomb_mask_bank_bench.sv
// self-checking bench of the loop one interrupt mask bank
// assumes lomb_pkg is compiled first; design assertions live in the design

`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) \
begin \
	checks++; \
	if ((got) !== (exp)) \
	begin \
		fails++; \
		$display("wrong value at %0t: %s", $time, msg); \
	end \
end

module lomb_mask_bank_bench;
	import lomb_pkg::*;

	// ----------------------------------------
	// signals
	// ----------------------------------------
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [LOMB_ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	lomb_ev_s ev = '0;
	logic irq;
	int fails = 0;
	int checks = 0;
	logic [31:0] rd;
	logic er;
	// writable mask bits and event bits, lock bank first
	logic [7:0] wr_t [5] = '{8'hFF, 8'hFD, 8'h1F, 8'h3F, 8'h1F};
	logic [7:0] ev_t [5] = '{8'hFF, 8'hFD, 8'h1C, 8'h3F, 8'h1F};

	always #5 pclk = ~pclk;

	lomb_mask_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev(ev), .irq(irq));

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic close_out;
		if (fails == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : close_out

	function automatic logic [11:0] ma(input int b);
		return {LOMB_LOCK_IDX + 10'(b), 2'b00};
	endfunction : ma

	function automatic logic [11:0] sa(input int b);
		return {LOMB_STAT_IDX + 10'(b), 2'b00};
	endfunction : sa

	// one apb transfer; waits for pready under a bound
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
		begin
			fails++;
			close_out();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	// one-cycle event pulse; irq is settled on return
	task automatic pulse(input int b, input int k);
		@(posedge pclk);
		ev <= lomb_ev_s'(40'h1 << (8 * b + k));
		@(posedge pclk);
		ev <= '0;
		#1;
	endtask : pulse

	task automatic do_reset;
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
	endtask : do_reset

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task automatic reset_values;
		for (int b = 0; b < LOMB_BANKS; b++)
		begin
			apb(1'b0, ma(b), '0);
			`CHK(rd, 32'h0, "mask after reset")
			apb(1'b0, sa(b), '0);
			`CHK(rd, 32'h0, "status after reset")
		end
		`CHK(irq, 1'b0, "irq after reset")
	endtask : reset_values

	task automatic mask_access;
		for (int b = 0; b < LOMB_BANKS; b++)
		begin
			apb(1'b1, ma(b), 32'hFFFF_FFFF);
			apb(1'b0, ma(b), '0);
			`CHK({er, rd}, {1'b0, 24'h0, wr_t[b]}, "mask read back")
			apb(1'b1, ma(b), 32'h0);
		end
	endtask : mask_access

	// every bit: masked event, late unmask, clear, then unmasked event
	task automatic event_bits;
		logic [7:0] m;
		logic x;
		for (int b = 0; b < LOMB_BANKS; b++)
			for (int k = 0; k < 8; k++)
			begin
				m = 8'h01 << k;
				x = ev_t[b][k];
				pulse(b, k);
				`CHK(irq, 1'b0, "masked event raised irq")
				apb(1'b0, sa(b), '0);
				`CHK(rd, {24'h0, x ? m : 8'h00}, "status after masked event")
				apb(1'b1, ma(b), {24'h0, m});
				`CHK(irq, x, "late unmask")
				apb(1'b1, sa(b), {24'h0, m});
				`CHK(irq, 1'b0, "irq after clear")
				pulse(b, k);
				`CHK(irq, x, "unmasked event")
				apb(1'b1, sa(b), {24'h0, m});
				apb(1'b1, ma(b), 32'h0);
				`CHK(irq, 1'b0, "irq idle")
			end
	endtask : event_bits

	// unmapped and misaligned accesses leave the lock mask alone
	task automatic refusals;
		apb(1'b1, 12'h000, 32'hFF);
		`CHK(er, 1'b1, "unmapped write accepted")
		apb(1'b1, 12'h459, 32'hFF);
		`CHK(er, 1'b1, "misaligned write accepted")
		apb(1'b0, 12'h000, '0);
		`CHK({er, rd}, {1'b1, 32'h0}, "unmapped read")
		apb(1'b0, ma(LOMB_B_LOCK), '0);
		`CHK(rd, 32'h0, "refused write landed")
	endtask : refusals

	// status clear and a new event on the same access edge: the event wins
	task automatic set_wins;
		apb(1'b1, ma(LOMB_B_LOCK), 32'h04);
		pulse(LOMB_B_LOCK, LOMB_FREQ_LK);
		fork
			apb(1'b1, sa(LOMB_B_LOCK), 32'h04);
			begin
				@(posedge pclk);
				@(posedge pclk);
				ev <= lomb_ev_s'(40'h04);
				@(posedge pclk);
				ev <= '0;
			end
		join
		`CHK(irq, 1'b1, "clear beat the event")
		apb(1'b0, sa(LOMB_B_LOCK), '0);
		`CHK(rd, 32'h4, "status lost to clear")
		apb(1'b1, sa(LOMB_B_LOCK), 32'h04);
		apb(1'b1, ma(LOMB_B_LOCK), 32'h0);
		`CHK(irq, 1'b0, "irq after final clear")
	endtask : set_wins

	task automatic reset_mid;
		apb(1'b1, ma(LOMB_B_LOCK), 32'hFF);
		pulse(LOMB_B_LOCK, 0);
		`CHK(irq, 1'b1, "irq before reset")
		do_reset();
		reset_values();
	endtask : reset_mid

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial
	begin
		do_reset();
		reset_values();
		mask_access();
		event_bits();
		refusals();
		set_wins();
		reset_mid();
		close_out();
	end

endmodule : lomb_mask_bank_bench

`default_nettype wire
